// *** hdl/uls_line_status.sv ***
// Line status logic with receive queue, transmit stage and APB slave
//
// Implementation choices: register access over APB and the register offsets.
`default_nettype none
// Operation
// [RULE1] Bit 7 set while any queued char flagged
// [RULE2] Bit 6 high when hold and shift empty
// [RULE3] Bit 5 high when hold stage empty
// [RULE4] Host may write 64 bytes after bit 5
// [RULE5] Break on bit 4, stored char 00
// [RULE6] Framing flag of head char on bit 3
// [RULE7] Parity flag of head char on bit 2
// [RULE8] Bit 1 set when receive overrun occurs
// [RULE9] Bit 0 high while receive queue nonempty
// [RULE10] Bits 4:2 taken from head queue entry
// [RULE11] Status read keeps pointer; data read advances
// [RULE12] Host reads status before receive data
// [RULE13] Fast clock: host reads status twice
// [RULE14] Error bits right by second read
// [RULE15] Reset clears error and data status bits
// [RULE16] Enable selects single holding or deep queues
// [RULE17] Status read clears overrun bit
// [RULE18] Flags travel with each queued char
module uls_line_status #(
  parameter int DEPTH = uls_pkg::FIFO_DEPTH,
  parameter int SHIFT_CYCLES = uls_pkg::TX_SHIFT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Received characters from the deserialiser
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_par_err,
  input wire logic rx_frm_err,
  input wire logic rx_break,
  // Transmit characters toward the serialiser
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_busy
);
  // Index width of both queues
  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [AW:0] rx_cnt;
    logic [AW:0] err_cnt;
    logic overrun;
    logic fifo_en;
    logic [AW-1:0] tx_rd;
    logic [AW-1:0] tx_wr;
    logic [AW:0] tx_cnt;
    logic [7:0] shift_cnt;
    logic shift_busy;
    logic [7:0] tx_data;
    logic tx_valid;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } uls_state_t;

  uls_state_t s_q, s_d;
  // Queue storage and the nets of the receive path
  uls_pkg::uls_rx_char_t rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  uls_pkg::uls_rx_char_t in_char;
  uls_pkg::uls_rx_char_t buf_char;
  uls_pkg::uls_rx_char_t head;
  logic buf_valid;
  logic buf_ready;
  logic rx_push;
  logic tx_push;
  logic [7:0] status;

  // Elaboration checks: the queue index wraps by power of two, the
  // level register shows each count in one byte, and the shift
  // counter is eight bits wide
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("uls_line_status: DEPTH must be a power of two");
  end
  if (DEPTH > 128) begin
    $error("uls_line_status: DEPTH too large for the level register");
  end
  if (SHIFT_CYCLES < 1 || SHIFT_CYCLES > 255) begin
    $error("uls_line_status: SHIFT_CYCLES out of range");
  end

  // Flag test of one queue entry
  function automatic logic has_err(input uls_pkg::uls_rx_char_t c);
    has_err = c.brk | c.frm | c.par;
  endfunction

  // Capacity in the current mode
  function automatic logic [AW:0] cap(input logic en);
    cap = en ? (AW+1)'(DEPTH) : (AW+1)'(1); // see [RULE16]
  endfunction

  // ****************************************************************
  // Receive path through the two-entry buffer
  // ****************************************************************
  // A break stores the zero character with its flag
  always_comb begin
    in_char.brk = rx_break;
    in_char.frm = rx_frm_err;
    in_char.par = rx_par_err;
    in_char.data = rx_break ? uls_pkg::BREAK_CHAR : rx_data; // see [RULE5]
  end

  // Two-entry buffer between the deserialiser and the queue
  uls_skid #(
    .WIDTH($bits(uls_pkg::uls_rx_char_t))
  ) u_rx_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(in_char),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_char)
  );

  // Buffer drains freely; a full queue drops the word as an overrun
  assign buf_ready = 1'b1;
  // Head entry is read straight from storage, never copied aside
  assign head = rx_mem[s_q.rd_ptr];
  assign rx_push = buf_valid && (s_q.rx_cnt < cap(s_q.fifo_en));
  // A hold write lands in the first access cycle, and only with room
  assign tx_push = psel && penable && pwrite && s_q.pready == 1'b0 &&
    paddr == uls_pkg::ADDR_TX_HOLD && (s_q.tx_cnt < cap(s_q.fifo_en));

  // ****************************************************************
  // Status word
  // ****************************************************************
  // Status byte as presented on a read of line_status
  always_comb begin
    status = 8'h00;
    status[uls_pkg::LS_FIFO_ERR] = (s_q.err_cnt != '0); // see [RULE1]
    status[uls_pkg::LS_TX_EMPTY] =
      (s_q.tx_cnt == '0) && !s_q.shift_busy; // see [RULE2]
    status[uls_pkg::LS_THR_EMPTY] = (s_q.tx_cnt == '0); // see [RULE3]
    if (s_q.rx_cnt != '0) begin
      // Head entry flags straight from queue see [RULE10] [RULE14]
      status[uls_pkg::LS_BREAK] = head.brk; // see [RULE5]
      status[uls_pkg::LS_FRAMING] = head.frm; // see [RULE6]
      status[uls_pkg::LS_PARITY] = head.par; // see [RULE7]
    end
    status[uls_pkg::LS_OVERRUN] = s_q.overrun; // see [RULE8]
    status[uls_pkg::LS_DATA_READY] = (s_q.rx_cnt != '0); // see [RULE9]
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic acc;
    logic rd_pop;
    logic tx_pop;
    logic known;
    logic flush;
    acc = 1'b0;
    rd_pop = 1'b0;
    tx_pop = 1'b0;
    known = 1'b0;
    flush = 1'b0;
    // Hold everything, then pulse the bus answer for one cycle
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // First access cycle of a transfer not yet answered
    acc = psel && penable && !s_q.pready;
    // Register map decode
    known = paddr == uls_pkg::ADDR_RX_HOLD ||
      paddr == uls_pkg::ADDR_TX_HOLD || paddr == uls_pkg::ADDR_CTRL ||
      paddr == uls_pkg::ADDR_LINE_STATUS || paddr == uls_pkg::ADDR_LEVEL;
    // One wait state, answer in the second access cycle
    if (acc) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !known;
      s_d.prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          uls_pkg::ADDR_RX_HOLD: begin
            s_d.prdata[7:0] = (s_q.rx_cnt != '0) ? head.data : 8'h00;
            rd_pop = (s_q.rx_cnt != '0); // see [RULE11]
          end
          // Mode bit read back in bit 0
          uls_pkg::ADDR_CTRL: s_d.prdata[0] = s_q.fifo_en;
          uls_pkg::ADDR_LINE_STATUS: begin
            s_d.prdata[7:0] = status; // pointer untouched see [RULE11]
          end
          uls_pkg::ADDR_LEVEL: begin
            s_d.prdata[15:8] = 8'(s_q.tx_cnt);
            s_d.prdata[7:0] = 8'(s_q.rx_cnt);
          end
          default: s_d.prdata = 32'h0000_0000;
        endcase
      end else if (paddr == uls_pkg::ADDR_CTRL) begin
        s_d.fifo_en = pwdata[uls_pkg::CTRL_FIFO_EN]; // see [RULE16]
        // Mode change flushes both queues, applied last below
        flush = (pwdata[uls_pkg::CTRL_FIFO_EN] != s_q.fifo_en);
      end
    end
    // Overrun: set wins over the clear by a status read
    if (acc && !pwrite && paddr == uls_pkg::ADDR_LINE_STATUS) begin
      s_d.overrun = 1'b0; // see [RULE17]
    end
    // A word that finds the queue full sets the flag
    if (buf_valid && !rx_push) begin
      s_d.overrun = 1'b1; // see [RULE8]
    end
    // Receive queue pointers and error count; flags stored per char
    if (rx_push) begin
      s_d.wr_ptr = s_q.wr_ptr + AW'(1); // see [RULE18]
    end
    if (rd_pop) begin
      s_d.rd_ptr = s_q.rd_ptr + AW'(1);
    end
    // Counts follow this cycle's pushes and pops
    s_d.rx_cnt = s_d.rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rd_pop);
    s_d.err_cnt = s_d.err_cnt + (AW+1)'(rx_push && has_err(buf_char))
      - (AW+1)'(rd_pop && has_err(head)); // see [RULE1]
    // Transmit: hold stage feeds shift stage, which counts a char time
    tx_pop = (s_q.tx_cnt != '0) && !s_q.shift_busy;
    s_d.tx_valid = tx_pop;
    if (tx_pop) begin
      s_d.tx_data = tx_mem[s_q.tx_rd];
      s_d.tx_rd = s_q.tx_rd + AW'(1);
      s_d.shift_busy = 1'b1;
      s_d.shift_cnt = 8'(SHIFT_CYCLES - 1);
    end else if (s_q.shift_busy) begin
      // Count one character time, then free the stage
      if (s_q.shift_cnt == 8'h00) begin
        s_d.shift_busy = 1'b0;
      end else begin
        s_d.shift_cnt = s_q.shift_cnt - 8'h01;
      end
    end
    // Hold stage fill from the bus; a full queue drops the byte
    if (tx_push) begin
      s_d.tx_wr = s_q.tx_wr + AW'(1); // see [RULE4]
    end
    s_d.tx_cnt = s_d.tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    // A mode change empties both queues last, so that a push or pop of
    // the same cycle cannot leave a count that disagrees with a pointer
    if (flush) begin
      s_d.rd_ptr = '0;
      s_d.wr_ptr = '0;
      s_d.rx_cnt = '0;
      s_d.err_cnt = '0;
      s_d.tx_rd = '0;
      s_d.tx_wr = '0;
      s_d.tx_cnt = '0;
    end
  end

  // ****************************************************************
  // Registers and queue storage
  // ****************************************************************
  // Reset clears every status source
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0; // see [RULE15]
    end else begin
      s_q <= s_d;
    end
  end

  // Queue memories, written without reset
  always_ff @(posedge sys_clk) begin
    if (rx_push) begin
      rx_mem[s_q.wr_ptr] <= buf_char; // see [RULE18]
    end
    // Hold stage stores the low byte of the bus word
    if (tx_push) begin
      tx_mem[s_q.tx_wr] <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every port but rx_ready driven straight from the state register
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign tx_valid = s_q.tx_valid;
  assign tx_data = s_q.tx_data;
  assign tx_busy = s_q.shift_busy;
endmodule
`default_nettype wire

// *** hdl/uls_pkg.sv ***
// Package of constants and carrier types for the line status block
`default_nettype none
package uls_pkg;
  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam logic [7:0] ADDR_RX_HOLD = 8'h00;
  localparam logic [7:0] ADDR_TX_HOLD = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL = 8'h10;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LS_FIFO_ERR = 7;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_BREAK = 4;
  localparam int LS_FRAMING = 3;
  localparam int LS_PARITY = 2;
  localparam int LS_OVERRUN = 1;
  localparam int LS_DATA_READY = 0;
  localparam int CTRL_FIFO_EN = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int FIFO_DEPTH = 64;
  localparam logic [7:0] BREAK_CHAR = 8'h00;
  // Transmit shift time per character in clock cycles
  localparam int TX_SHIFT_CYCLES = 16;

  // Character with its own error flags, as kept in the receive queue
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } uls_rx_char_t;

  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } uls_apb_req_t;
endpackage
`default_nettype wire

// *** hdl/uls_skid.sv ***
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module uls_skid #(
  parameter int WIDTH = 11
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] cnt;
    logic room;
  } uls_skid_state_t;

  uls_skid_state_t s_q, s_d;

  // Elaboration check of the word width
  if (WIDTH < 1) begin
    $error("uls_skid: WIDTH must be positive");
  end

  // Head in slot 0, second word in slot 1
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    s_d = s_q;
    push = in_valid && (s_q.cnt != 2'd2);
    pop = out_ready && (s_q.cnt != 2'd0);
    if (pop) begin
      s_d.mem[0] = s_q.mem[1];
      s_d.cnt = s_q.cnt - 2'd1;
    end
    if (push) begin
      s_d.mem[s_d.cnt[0]] = in_data;
      s_d.cnt = s_d.cnt + 2'd1;
    end
    // Room flag kept in a flip-flop so that the ready port is registered
    s_d.room = (s_d.cnt != 2'd2);
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{mem: '0, cnt: 2'd0, room: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.room;
  assign out_valid = (s_q.cnt != 2'd0);
  assign out_data = s_q.mem[0];
endmodule
`default_nettype wire

// *** tb/uls_host.sv ***
// Host processor model on the APB side
`default_nettype none
module uls_host (
  // Clock
  input wire logic sys_clk,
  // APB master
  output var logic psel = 1'b0,
  output var logic penable = 1'b0,
  output var logic pwrite = 1'b0,
  output var logic [7:0] paddr = 8'h00,
  output var logic [31:0] pwdata = 32'h0,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Setup, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/uls_line_status_monitor.sv ***
// Port checker of the line status block
`default_nettype none
module uls_line_status_monitor #(
  parameter int DEPTH = 64,
  parameter int SHIFT_CYCLES = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Streams
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic st_rd;
  // Status read answered in this cycle
  assign st_rd = pready && !pwrite && paddr == uls_pkg::ADDR_LINE_STATUS;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  answer_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB answer not in time");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_map_a: assert property (psel && penable && !pready &&
    paddr > uls_pkg::ADDR_LEVEL |=> pslverr && pready)
    else $error("unmapped access not refused");
  err_summary_a: assert property (st_rd && (|prdata[4:2]) |->
    prdata[7] && prdata[0]) else $error("flag without summary");
  tx_empty_a: assert property (st_rd && prdata[6] |-> prdata[5])
    else $error("empty bits disagree");
  shift_busy_a: assert property (st_rd && tx_busy && $past(tx_busy)
    |-> !prdata[6]) else $error("empty while shifting");
  rx_accept_a: assert property (rx_ready)
    else $error("receive buffer stalled");
  tx_start_a: assert property (tx_valid |=> tx_busy && !tx_valid)
    else $error("shift stage not busy");
  reset_quiet_a: assert property (disable iff (1'b0) rst |->
    !pready && !tx_valid && !tx_busy && prdata == 32'h0)
    else $error("outputs active in reset");
  cover property (st_rd && prdata[0]);
  cover property (st_rd && prdata[1]);
  cover property (tx_valid);
endmodule
bind uls_line_status uls_line_status_monitor #(.DEPTH(DEPTH),
  .SHIFT_CYCLES(SHIFT_CYCLES)) mon (.sys_clk(sys_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_busy(tx_busy));
`default_nettype wire

// *** tb/uls_line_status_tb.sv ***
// Self-checking bench of the line status block
`default_nettype none
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin fails++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, x); end end
module uls_line_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, tx_data;
  logic [31:0] pwdata, prdata, q;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_par_err = 1'b0;
  logic rx_frm_err = 1'b0;
  logic rx_break = 1'b0;
  logic rx_ready, tx_valid, tx_busy, ovr;
  int fails = 0;
  int checks = 0;
  uls_pkg::uls_rx_char_t exp_q[$];
  logic [7:0] tx_q[$], tx_exp[$];
  always #2 sys_clk = ~sys_clk;
  uls_line_status #(.DEPTH(DEPTH), .SHIFT_CYCLES(8)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_par_err(rx_par_err),
    .rx_frm_err(rx_frm_err), .rx_break(rx_break), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_busy(tx_busy));
  uls_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  // Collect characters handed to the serialiser
  always @(posedge sys_clk) if (tx_valid === 1'b1) tx_q.push_back(tx_data);
  // Expected status byte from the queue model
  function automatic logic [7:0] stat_f();
    logic [7:0] s;
    s = {2'b01, 1'b1, 3'b000, ovr, exp_q.size() != 0};
    s[6] = 1'b1;
    foreach (exp_q[i]) s[7] |= exp_q[i].brk | exp_q[i].frm | exp_q[i].par;
    if (exp_q.size() != 0) s[4:2] = {exp_q[0].brk, exp_q[0].frm, exp_q[0].par};
    return s;
  endfunction
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    host.xfer(1'b0, a, 32'h0, q, e);
    `CHK(q, {24'h0, x})
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  // Offer n random characters back to back
  task automatic push(input int n, input int cap);
    uls_pkg::uls_rx_char_t c;
    repeat (n) begin
      @(posedge sys_clk);
      c = 11'($urandom);
      rx_valid <= 1'b1;
      {rx_break, rx_frm_err, rx_par_err, rx_data} <= c;
      if (c.brk) c.data = uls_pkg::BREAK_CHAR;
      if (exp_q.size() < cap) exp_q.push_back(c);
      else ovr = 1'b1;
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    void'($urandom(87402));
    ovr = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(uls_pkg::ADDR_LINE_STATUS, 8'h60);
    host.xfer(1'b0, 8'h40, 32'h0, q, e);
    `CHK(e, 1'b1)
    for (int m = 0; m < 4; m++) begin
      wr(uls_pkg::ADDR_CTRL, 32'(m != 0));
      push(m == 0 ? 2 : m == 1 ? DEPTH + 1 : 1 + $urandom_range(DEPTH - 1),
        m == 0 ? 1 : DEPTH);
      while (exp_q.size() != 0) begin
        rd(uls_pkg::ADDR_LINE_STATUS, stat_f());
        ovr = 1'b0;
        rd(uls_pkg::ADDR_LINE_STATUS, stat_f());
        rd(uls_pkg::ADDR_RX_HOLD, exp_q.pop_front().data);
      end
      rd(uls_pkg::ADDR_LINE_STATUS, 8'h60);
    end
    // Reset in mid-run with a full queue and an overrun pending
    push(DEPTH + 1, DEPTH);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    exp_q.delete();
    ovr = 1'b0;
    rd(uls_pkg::ADDR_LINE_STATUS, 8'h60);
    wr(uls_pkg::ADDR_CTRL, 32'h1);
    for (int i = 0; i < DEPTH; i++) begin
      tx_exp.push_back(8'($urandom));
      wr(uls_pkg::ADDR_TX_HOLD, {24'h0, tx_exp[i]});
    end
    rd(uls_pkg::ADDR_LINE_STATUS, 8'h00);
    for (int i = 0; i < 400 && (tx_q.size() < DEPTH || tx_busy !== 1'b0); i++)
      @(posedge sys_clk);
    foreach (tx_exp[i]) `CHK(tx_q[i], tx_exp[i])
    rd(uls_pkg::ADDR_LINE_STATUS, 8'h60);
    results();
  end
endmodule
`default_nettype wire
